// File: core/ocs_osc_ctrl.sv
// Oscillator source selection, slow crystal power mode and pin sharing control.
module ocs_osc_ctrl (
  input wire logic clock,
  input wire logic reset,
  input wire ocs_pkg::ocs_cfg_t cfg,
  input wire logic ctrl_write,
  input wire logic [7:0] ctrl_wdata,
  input wire logic halt_request,
  input wire logic wake_request,
  input wire logic oscillator_pin_first,
  input wire logic oscillator_pin_second,
  output logic [7:0] ctrl_rdata,
  output logic sys_clk_tick,
  output logic slow_xtal_tick,
  output logic slow_rc_tick,
  output logic slow_xtal_low_power,
  output logic fast_rc_running,
  output logic low_speed_active,
  output logic halted,
  output logic port_a_bit_five_gpio,
  output logic port_a_bit_six_gpio
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    ocs_pkg::ocs_ctrl_t ctrl;
    ocs_pkg::ocs_sw_state_t sw;
    logic halted;
    logic [2:0] pin1_sync;
    logic [1:0] pin2_sync;
    logic sys_tick;
    logic xtal_tick;
    logic rc_tick;
    logic fast_run;
    logic pa5_gpio;
    logic pa6_gpio;
    logic slow_act;
    logic [15:0] rc_gap;
  } ocs_state_t;

  ocs_state_t st_q;
  ocs_state_t st_d;
  logic frc_tick;
  logic src_tick;
  logic frc_enable;
  logic [31:0] frc_inc;

  // Only three codes exist; the spare code falls back to the slowest setting.
  function automatic logic [31:0] frc_increment(input ocs_pkg::ocs_frc_freq_t sel);
    logic [31:0] inc;
    inc = ocs_pkg::INC_4M;
    if (sel == ocs_pkg::FRC_8MHZ) begin
      inc = ocs_pkg::INC_8M;
    end else if (sel == ocs_pkg::FRC_12MHZ) begin
      inc = ocs_pkg::INC_12M;
    end
    return inc;
  endfunction

  // ------------------------------------------------------------------
  // Internal oscillators
  // ------------------------------------------------------------------
  // The fast RC stops in slow mode and while halted.
  assign frc_enable = (st_q.sw != ocs_pkg::SW_SLOW) && !st_q.halted
    && (cfg.osc_type inside {ocs_pkg::OSC_INTERNAL_FAST_RC, ocs_pkg::OSC_FAST_RC_SLOW_XTAL});
  assign frc_inc = frc_increment(cfg.fast_rc_freq);

  ocs_tick_gen #(.ACC_W(ocs_pkg::ACC_W)) fast_rc_gen (
    .clock(clock),
    .reset(reset),
    .enable(frc_enable),
    .increment(frc_inc),
    .tick_q(frc_tick)
  );

  // The slow RC is free running; only the configuration option stops it.
  ocs_tick_gen #(.ACC_W(ocs_pkg::ACC_W)) slow_rc_gen (
    .clock(clock),
    .reset(reset),
    .enable(cfg.slow_rc_enable),
    .increment(ocs_pkg::INC_SLOW_RC),
    .tick_q(src_tick)
  );

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    logic pin_edge;
    logic paired;
    logic want_slow;
    logic fast_src;
    pin_edge = st_q.pin1_sync[1] && !st_q.pin1_sync[2];
    paired = cfg.osc_type == ocs_pkg::OSC_FAST_RC_SLOW_XTAL;
    want_slow = paired && st_q.ctrl.system_clock_source_select;
    fast_src = (cfg.osc_type == ocs_pkg::OSC_INTERNAL_FAST_RC || paired) ? frc_tick : pin_edge;
    st_d = st_q;

    // Pin synchronisers; only stage two and later feed logic.
    st_d.pin1_sync = {st_q.pin1_sync[1:0], oscillator_pin_first};
    st_d.pin2_sync = {st_q.pin2_sync[0], oscillator_pin_second};

    // Control bits; bits other than the two fields are not held here.
    if (ctrl_write) begin
      st_d.ctrl.slow_xtal_power_mode = ctrl_wdata[ocs_pkg::CTRL_POWER_MODE_BIT];
      st_d.ctrl.system_clock_source_select = ctrl_wdata[ocs_pkg::CTRL_CLK_SEL_BIT];
    end

    // Halt wins over a wake in the same cycle so a halt is never lost.
    if (halt_request) begin
      st_d.halted = 1'b1;
    end else if (wake_request) begin
      st_d.halted = 1'b0;
    end

    // The slow crystal runs whatever the power mode and through halt.
    st_d.xtal_tick = paired && pin_edge;
    st_d.rc_tick = src_tick;

    // Switching waits for the first edge of the new source, so no short period escapes.
    st_d.sys_tick = 1'b0;
    case (st_q.sw)
      ocs_pkg::SW_FAST: begin
        if (want_slow) begin
          st_d.sw = ocs_pkg::SW_TO_SLOW;
        end else begin
          st_d.sys_tick = fast_src;
        end
      end
      ocs_pkg::SW_TO_SLOW: begin
        if (!want_slow) begin
          st_d.sw = ocs_pkg::SW_FAST;
        end else if (pin_edge) begin
          st_d.sw = ocs_pkg::SW_SLOW;
          st_d.sys_tick = 1'b1;
        end
      end
      ocs_pkg::SW_SLOW: begin
        if (!want_slow) begin
          st_d.sw = ocs_pkg::SW_TO_FAST;
        end else begin
          st_d.sys_tick = pin_edge;
        end
      end
      ocs_pkg::SW_TO_FAST: begin
        if (want_slow) begin
          st_d.sw = ocs_pkg::SW_SLOW;
        end else if (fast_src) begin
          st_d.sw = ocs_pkg::SW_FAST;
          st_d.sys_tick = 1'b1;
        end
      end
      default: begin
        st_d.sw = ocs_pkg::SW_FAST;
      end
    endcase
    // Idle and Sleep hold the processor clock off from the cycle the halt shows.
    if (st_d.halted) begin
      st_d.sys_tick = 1'b0;
    end

    st_d.fast_run = frc_enable;
    // Registered here so that the slow-mode flag leaves the block straight from a flip-flop.
    st_d.slow_act = st_d.sw == ocs_pkg::SW_SLOW;
    // Pin sharing follows the oscillator option.
    st_d.pa5_gpio = cfg.osc_type inside {ocs_pkg::OSC_EXTERNAL_RC, ocs_pkg::OSC_INTERNAL_FAST_RC};
    st_d.pa6_gpio = cfg.osc_type == ocs_pkg::OSC_INTERNAL_FAST_RC;

    // Cycles since the last slow RC tick, kept for checking; held at zero while the
    // oscillator is disabled so that a restart does not count the idle time as a gap.
    st_d.rc_gap = (st_q.rc_tick || !cfg.slow_rc_enable) ? 16'h0000 : st_q.rc_gap + 16'h0001;
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  // Power-on clears both control bits, so the slow crystal starts quickly.
  always_ff @(posedge clock) begin
    if (reset) begin
      st_q <= '0;
      st_q.sw <= ocs_pkg::SW_FAST;
      st_q.ctrl <= ocs_pkg::ocs_ctrl_t'(ocs_pkg::CTRL_RESET[1:0]);
      st_q.pa5_gpio <= 1'b0;
      st_q.pa6_gpio <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs come straight from the state register.
  assign ctrl_rdata = {6'h00, st_q.ctrl.slow_xtal_power_mode, st_q.ctrl.system_clock_source_select};
  assign sys_clk_tick = st_q.sys_tick;
  assign slow_xtal_tick = st_q.xtal_tick;
  assign slow_rc_tick = st_q.rc_tick;
  // Software is expected to raise this bit once the crystal has settled.
  assign slow_xtal_low_power = st_q.ctrl.slow_xtal_power_mode;
  assign fast_rc_running = st_q.fast_run;
  assign low_speed_active = st_q.slow_act;
  assign halted = st_q.halted;
  assign port_a_bit_five_gpio = st_q.pa5_gpio;
  assign port_a_bit_six_gpio = st_q.pa6_gpio;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence pin_rise_s;
    $rose(st_q.pin1_sync[1]) && cfg.osc_type == ocs_pkg::OSC_FAST_RC_SLOW_XTAL;
  endsequence

  sequence xtal_tick_s;
    ##1 slow_xtal_tick;
  endsequence

  sequence halt_enter_s;
    halt_request ##1 halted;
  endsequence

  sequence slow_entry_s;
    $rose(low_speed_active);
  endsequence

  sequence wake_only_s;
    wake_request && !halt_request;
  endsequence

  reset_clears_ctrl_a: assert property (disable iff (1'b0) reset |=> ctrl_rdata == 8'h00)
    else $error("control bits not cleared by reset");
  power_mode_out_a: assert property (ctrl_write |=> slow_xtal_low_power == $past(ctrl_wdata[1]))
    else $error("power mode output does not follow the written bit");
  halt_stops_clock_a: assert property (halt_enter_s |-> !sys_clk_tick)
    else $error("system clock tick while halted");
  slow_rc_gap_a: assert property (cfg.slow_rc_enable[*3] |-> rc_gap_ok())
    else $error("slow rc tick overdue");
  slow_rc_off_a: assert property ((!cfg.slow_rc_enable)[*2] |=> !slow_rc_tick)
    else $error("slow rc ticks while disabled");
  xtal_edge_tick_a: assert property (pin_rise_s |-> xtal_tick_s)
    else $error("slow crystal edge gave no tick");
  select_ignored_a: assert property (cfg.osc_type != ocs_pkg::OSC_FAST_RC_SLOW_XTAL
    && $past(cfg.osc_type) == cfg.osc_type |=> ##1 !low_speed_active)
    else $error("slow clock used outside paired option");
  fast_rc_stopped_a: assert property (low_speed_active |=> !fast_rc_running)
    else $error("fast rc still running in slow mode");
  pins_rc_a: assert property (cfg.osc_type == ocs_pkg::OSC_EXTERNAL_RC
    |=> port_a_bit_five_gpio && !port_a_bit_six_gpio)
    else $error("external rc pin sharing wrong");
  pins_free_a: assert property (cfg.osc_type == ocs_pkg::OSC_INTERNAL_FAST_RC
    |=> port_a_bit_five_gpio && port_a_bit_six_gpio)
    else $error("fast rc did not free both pins");
  switch_quiet_a: assert property ((st_q.sw == ocs_pkg::SW_TO_SLOW && !$rose(st_q.pin1_sync[1]))
    |=> !sys_clk_tick)
    else $error("clock tick during source switch");

  // Halt and wake each take effect one cycle after the request edge.
  halt_enter_a: assert property (halt_request |=> halted)
    else $error("halt request did not halt the clock");
  wake_clears_a: assert property (wake_only_s |=> !halted)
    else $error("wake request did not leave halt");
  // The whole halt must be free of processor ticks, not only its first cycle.
  halted_no_tick_a: assert property (halted |-> !sys_clk_tick)
    else $error("system clock tick during halt");
  fast_rc_halt_a: assert property (halted |=> !fast_rc_running)
    else $error("fast rc running during halt");
  // The power-mode bit only moves on a write.
  power_mode_hold_a: assert property (!ctrl_write |=> $stable(slow_xtal_low_power))
    else $error("power mode changed without a write");
  // Slow mode may only be entered with the select bit set in the paired option.
  slow_entry_sel_a: assert property (slow_entry_s |->
    $past(ctrl_rdata[ocs_pkg::CTRL_CLK_SEL_BIT])
    && $past(cfg.osc_type) == ocs_pkg::OSC_FAST_RC_SLOW_XTAL)
    else $error("slow mode entered without select in paired option");
  // Once settled in slow mode the processor clock is the crystal clock, edge for edge.
  slow_tick_follow_a: assert property (
    low_speed_active && $past(low_speed_active) && !halted |-> sys_clk_tick == slow_xtal_tick)
    else $error("slow mode clock does not follow the crystal");
  // The paired option claims both pins, and only it gives crystal ticks.
  pins_xtal_a: assert property (cfg.osc_type == ocs_pkg::OSC_FAST_RC_SLOW_XTAL
    |=> !port_a_bit_five_gpio && !port_a_bit_six_gpio)
    else $error("slow crystal pins left free");
  xtal_only_paired_a: assert property (cfg.osc_type != ocs_pkg::OSC_FAST_RC_SLOW_XTAL
    |=> !slow_xtal_tick)
    else $error("slow crystal tick outside paired option");

  // Gap bound for the slow RC.
  function automatic logic rc_gap_ok();
    return st_q.rc_gap <= ocs_pkg::SLOW_RC_GAP_MAX;
  endfunction

endmodule // ocs_osc_ctrl

// File: core/ocs_pkg.sv
// Package of constants and types for the oscillator source controller.
package ocs_pkg;

  // ------------------------------------------------------------------
  // Timing and frequencies
  // ------------------------------------------------------------------
  localparam longint CLK_HZ = 100000000;
  localparam longint FAST_RC_4M_HZ = 4000000;
  localparam longint FAST_RC_8M_HZ = 8000000;
  localparam longint FAST_RC_12M_HZ = 12000000;
  localparam longint SLOW_RC_HZ = 13000;
  localparam longint SLOW_XTAL_HZ = 32768;
  localparam int ACC_W = 32;
  // Phase increments for a 32-bit accumulator at the core clock rate.
  localparam logic [31:0] INC_4M = 32'((FAST_RC_4M_HZ << ACC_W) / CLK_HZ);
  localparam logic [31:0] INC_8M = 32'((FAST_RC_8M_HZ << ACC_W) / CLK_HZ);
  localparam logic [31:0] INC_12M = 32'((FAST_RC_12M_HZ << ACC_W) / CLK_HZ);
  localparam logic [31:0] INC_SLOW_RC = 32'((SLOW_RC_HZ << ACC_W) / CLK_HZ);
  // Longest gap between two slow RC ticks, in core clock cycles.
  localparam logic [15:0] SLOW_RC_GAP_MAX = 16'(CLK_HZ / SLOW_RC_HZ + 2);

  // ------------------------------------------------------------------
  // First system control register fields
  // ------------------------------------------------------------------
  localparam int CTRL_W = 8;
  localparam int CTRL_CLK_SEL_BIT = 0;
  localparam int CTRL_POWER_MODE_BIT = 1;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ------------------------------------------------------------------
  // Configuration options
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    OSC_FAST_CRYSTAL = 2'h0,
    OSC_EXTERNAL_RC = 2'h1,
    OSC_INTERNAL_FAST_RC = 2'h2,
    OSC_FAST_RC_SLOW_XTAL = 2'h3
  } ocs_osc_type_t;

  typedef enum logic [1:0] {
    FRC_4MHZ = 2'h0,
    FRC_8MHZ = 2'h1,
    FRC_12MHZ = 2'h2
  } ocs_frc_freq_t;

  // Clock switch states, one-hot.
  typedef enum logic [3:0] {
    SW_FAST = 4'h1,
    SW_TO_SLOW = 4'h2,
    SW_SLOW = 4'h4,
    SW_TO_FAST = 4'h8
  } ocs_sw_state_t;

  typedef struct packed {
    logic slow_xtal_power_mode;
    logic system_clock_source_select;
  } ocs_ctrl_t;

  typedef struct packed {
    ocs_osc_type_t osc_type;
    ocs_frc_freq_t fast_rc_freq;
    logic slow_rc_enable;
  } ocs_cfg_t;

endpackage : ocs_pkg

// File: core/ocs_tick_gen.sv
// Phase-accumulator tick generator modelling an on-chip RC oscillator.
module ocs_tick_gen #(
  parameter int ACC_W = 32
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic enable,
  input wire logic [ACC_W-1:0] increment,
  output logic tick_q
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic tick;
  } ocs_tg_state_t;

  ocs_tg_state_t st_q;
  ocs_tg_state_t st_d;

  // A stopped oscillator restarts from phase zero, so its first tick is a full period.
  always_comb begin
    logic [ACC_W:0] sum;
    sum = '0;
    st_d = st_q;
    if (enable) begin
      sum = {1'b0, st_q.acc} + {1'b0, increment};
      st_d.acc = sum[ACC_W-1:0];
      st_d.tick = sum[ACC_W];
    end else begin
      st_d.acc = '0;
      st_d.tick = 1'b0;
    end
  end

  // Registers the state.
  always_ff @(posedge clock) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tick_q = st_q.tick;

endmodule // ocs_tick_gen

// File: verif/ocs_osc_ctrl_tb_top.sv
// Self-checking testbench for the oscillator source controller.
module ocs_osc_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock, reset, ctrl_write, halt_request, wake_request, pin_first, pin_second;
  ocs_pkg::ocs_cfg_t cfg;
  logic [7:0] ctrl_wdata, ctrl_rdata;
  logic sys_clk_tick, slow_xtal_tick, slow_rc_tick, slow_xtal_low_power;
  logic fast_rc_running, low_speed_active, halted, gpio_five, gpio_six;
  logic pin_run;
  logic [31:0] rng;
  int err_count, n_compared, cycles, pin_cnt;
  int n_sys, n_xtal, n_rc, n_edge, rc_gap, rc_gap_max;

  ocs_osc_ctrl u_ocs_osc_ctrl (
    .clock(clock), .reset(reset), .cfg(cfg), .ctrl_write(ctrl_write),
    .ctrl_wdata(ctrl_wdata), .halt_request(halt_request), .wake_request(wake_request),
    .oscillator_pin_first(pin_first), .oscillator_pin_second(pin_second),
    .ctrl_rdata(ctrl_rdata), .sys_clk_tick(sys_clk_tick), .slow_xtal_tick(slow_xtal_tick),
    .slow_rc_tick(slow_rc_tick), .slow_xtal_low_power(slow_xtal_low_power),
    .fast_rc_running(fast_rc_running), .low_speed_active(low_speed_active),
    .halted(halted), .port_a_bit_five_gpio(gpio_five), .port_a_bit_six_gpio(gpio_six)
  );

  // The crystal drives its second pin in antiphase to the first.
  assign pin_second = ~pin_first;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Fast RC ticks expected in n cycles; code 3 falls back to the lowest rate.
  function automatic int fast_exp(input logic [1:0] f, input int n);
    longint hz;
    hz = (f == 2'h1) ? ocs_pkg::FAST_RC_8M_HZ :
         (f == 2'h2) ? ocs_pkg::FAST_RC_12M_HZ : ocs_pkg::FAST_RC_4M_HZ;
    return int'(n * hz / ocs_pkg::CLK_HZ);
  endfunction

  // Free-pin flags {bit five, bit six} for each oscillator type.
  function automatic logic [1:0] gpio_exp(input logic [1:0] t);
    return (t == 2'h1) ? 2'b10 : (t == 2'h2) ? 2'b11 : 2'b00;
  endfunction

  // Counts compared with one tick of slack, since edge phase is arbitrary.
  function automatic logic [31:0] near(input int s, input int e);
    return (s >= e - 1 && s <= e + 1) ? e : s;
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    if (err_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] d);
    @(posedge clock);
    ctrl_write <= 1'b1;
    ctrl_wdata <= d;
    @(posedge clock);
    ctrl_write <= 1'b0;
    @(negedge clock);
  endtask

  task automatic set_cfg(input logic [1:0] t, input logic [1:0] f, input logic rc);
    @(posedge clock);
    cfg <= ocs_pkg::ocs_cfg_t'({t, f, rc});
    @(negedge clock);
  endtask

  // Counters are cleared on the falling edge, away from the counting edge.
  task automatic window(input int n);
    @(negedge clock);
    n_sys = 0;
    n_xtal = 0;
    n_rc = 0;
    n_edge = 0;
    rc_gap_max = 0;
    repeat (n) @(negedge clock);
  endtask

  task automatic pulse(input logic halt);
    @(posedge clock);
    if (halt) halt_request <= 1'b1;
    else wake_request <= 1'b1;
    @(posedge clock);
    halt_request <= 1'b0;
    wake_request <= 1'b0;
    @(negedge clock);
  endtask

  // ------------------------------------------------------------------
  // Clock, slow crystal stand-in, tick counters and hang guard
  // ------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // The crystal is scaled to a 40-cycle period so that runs stay short.
  always @(posedge clock) begin
    cycles++;
    if (cycles >= 70000) begin
      err_count++;
      finish_test();
    end
    n_sys += int'(sys_clk_tick === 1'b1);
    n_xtal += int'(slow_xtal_tick === 1'b1);
    n_rc += int'(slow_rc_tick === 1'b1);
    rc_gap = (slow_rc_tick === 1'b1) ? 0 : rc_gap + 1;
    if (rc_gap > rc_gap_max) rc_gap_max = rc_gap;
    pin_cnt++;
    if (pin_run && pin_cnt >= 20) begin
      pin_cnt = 0;
      pin_first <= ~pin_first;
      if (!pin_first) n_edge++;
    end
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    reset = 1'b1;
    ctrl_write = 1'b0;
    ctrl_wdata = 8'h00;
    halt_request = 1'b0;
    wake_request = 1'b0;
    pin_first = 1'b0;
    pin_run = 1'b0;
    cfg = ocs_pkg::ocs_cfg_t'(5'h19);
    rng = 32'h3826391d;
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    @(negedge clock);
    check("rdata_por", 32'(ctrl_rdata), 32'h0);
    check("low_power_por", 32'(slow_xtal_low_power), 32'h0);
    pin_run = 1'b1;
    for (int i = 0; i < 12; i++) begin
      rng = xs(rng);
      wr((i == 0) ? 8'hfc : rng[7:0]);
      check("rdata", 32'(ctrl_rdata), {30'h0, (i == 0) ? 2'h0 : rng[1:0]});
      check("low_power", 32'(slow_xtal_low_power), (i == 0) ? 32'h0 : 32'(rng[1]));
    end
    wr(8'h00);
    for (int f = 0; f < 4; f++) begin
      set_cfg(2'h2, 2'(f), 1'b1);
      window(3000);
      check("fast_ticks", near(n_sys, fast_exp(2'(f), 3000)), fast_exp(2'(f), 3000));
      check("xtal_off", 32'(n_xtal), 32'h0);
    end
    for (int t = 0; t < 4; t++) begin
      set_cfg(2'(t), 2'h1, 1'b1);
      window(800);
      check("pins_free", 32'({gpio_five, gpio_six}), 32'(gpio_exp(2'(t))));
      check("xtal_ticks", near(n_xtal, n_edge), (t == 3) ? n_edge : 0);
    end
    // Low-power mode must not disturb the slow crystal clock.
    wr(8'h02);
    window(800);
    check("xtal_low_power", near(n_xtal, n_edge), n_edge);
    wr(8'h03);
    for (int k = 0; k < 200 && low_speed_active !== 1'b1; k++) @(negedge clock);
    repeat (3) @(negedge clock);
    check("low_speed_on", 32'({low_speed_active, fast_rc_running}), 32'h2);
    window(800);
    check("slow_sys_ticks", near(n_sys, n_edge), n_edge);
    wr(8'h00);
    for (int k = 0; k < 200 && low_speed_active !== 1'b0; k++) @(negedge clock);
    repeat (3) @(negedge clock);
    check("low_speed_off", 32'({low_speed_active, fast_rc_running}), 32'h1);
    // The select bit must be ignored outside the paired configuration.
    for (int t = 0; t < 3; t++) begin
      set_cfg(2'(t), 2'h0, 1'b1);
      wr(8'h01);
      repeat (60) @(negedge clock);
      check("select_ignored", 32'(low_speed_active), 32'h0);
      wr(8'h00);
    end
    set_cfg(2'h3, 2'h0, 1'b1);
    rng = xs(rng);
    repeat (rng[3:0]) @(posedge clock);
    pulse(1'b1);
    check("halted", 32'(halted), 32'h1);
    window(16000);
    check("sys_stopped", 32'(n_sys), 32'h0);
    check("rc_ticks", near(n_rc, 2), 32'h2);
    check("rc_gap", 32'(rc_gap_max < int'(ocs_pkg::SLOW_RC_GAP_MAX)), 32'h1);
    check("xtal_halted", near(n_xtal, n_edge), n_edge);
    pulse(1'b0);
    check("woken", 32'(halted), 32'h0);
    set_cfg(2'h3, 2'h0, 1'b0);
    window(16000);
    check("rc_disabled", 32'(n_rc), 32'h0);
    finish_test();
  end

endmodule // ocs_osc_ctrl_tb_top
